// File: core/csie_pkg.sv
// Constants shared by the clock-source interrupt-enable block
package csie_pkg;

    // Register word offsets on the plain register port (byte addresses)
    localparam logic [7:0] OFF_ENABLE_CLEAR = 8'h00; // irq_enable_clear_view
    localparam logic [7:0] OFF_ENABLE_SET = 8'h04; // irq_enable_set_view
    localparam logic [7:0] OFF_FLAG = 8'h08; // irq_flag_register
    localparam logic [7:0] OFF_STATUS = 8'h0c; // clock_power_status_register copy

    // Bit positions of the implemented sources
    localparam int BIT_PLL_LOCK_TIMEOUT = 17;
    localparam int BIT_PLL_LOCK_FALL = 16;
    localparam int BIT_PLL_LOCK_RISE = 15;
    localparam int BIT_BROWNOUT_SYNC_READY = 11;
    localparam int BIT_BROWNOUT_DETECT = 10;
    localparam int BIT_BROWNOUT_READY = 9;
    localparam int BIT_FLL_REF_STOPPED = 8;
    localparam int BIT_FLL_LOCK_COARSE = 7;
    localparam int BIT_FLL_LOCK_FINE = 6;
    localparam int BIT_FLL_OUT_OF_BOUNDS = 5;
    localparam int BIT_FLL_READY = 4;
    localparam int BIT_RC8M_READY = 3;
    localparam int BIT_RC32K_READY = 2;
    localparam int BIT_XTAL32K_READY = 1;
    localparam int BIT_XTAL_READY = 0;

    // Number of status lines entering the block (bits 17:0)
    localparam int NUM_SRC = 18;

    // Mask of implemented bits; 31:18 and 14:12 are reserved
    localparam logic [31:0] IMPL_MASK = 32'h0003_8fff;

    // Reset values
    localparam logic [31:0] RESET_ENABLE = 32'h0000_0000;
    localparam logic [31:0] RESET_FLAG = 32'h0000_0000;
    localparam logic [31:0] READ_IDLE = 32'h0000_0000;

endpackage : csie_pkg

// File: core/csie_top.sv
// Interrupt-enable mask, event flags and request output of the clock controller
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Function
// - Clear view: written ones clear enables
// - Written zeros leave enables unchanged
// - Set view: written ones set enables
// - Both views read one shared mask
// - Enabling needs one write, no read-modify-write
// - Enabled set flag raises interrupt request
// - Reserved bits ignore writes, read zero
// - PLL enables at bits 17, 16, 15
// - Brown-out enables at bits 11, 10, 9
// - FLL enables at bits 8, 7, 6
// - FLL bounds bit 5, ready bit 4
// - Internal oscillator enables at bits 3, 2
// - Crystal oscillator enables at bits 1, 0
// - Write protection blocks enable view writes
// - Flags set on status rise, write-one clears
module csie_top #(
    parameter int ADDR_W = 8, // Register address width
    parameter int DATA_W = 32 // Register data width
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Protection from the peripheral_access_guard
    input wire logic write_protect,
    // Raw status levels from oscillators, loops and brown-out detector
    input wire logic [csie_pkg::NUM_SRC-1:0] src_status,
    // Interrupt request and enable mask
    output logic irq_req,
    output logic [DATA_W-1:0] irq_enable_mask
);

    ////////////////////////////////////////////////////////////////////////////
    // State of the block

    // Every flip-flop of the core apart from the reset synchroniser sits in this one record
    typedef struct packed {
        logic [31:0] enable; // Shared enable mask of both views
        logic [31:0] flag; // Sticky event flags
        logic [csie_pkg::NUM_SRC-1:0] sync1; // First stage, read only by sync2
        logic [csie_pkg::NUM_SRC-1:0] sync2; // Second stage
        logic [csie_pkg::NUM_SRC-1:0] sync3; // Third stage
        logic [csie_pkg::NUM_SRC-1:0] level; // Accepted, filtered status level
        logic [31:0] rdata; // Read data, valid the cycle after the strobe
        logic irq; // Registered request
    } csie_state_t;

    localparam csie_state_t STATE_RESET = '{
        enable: csie_pkg::RESET_ENABLE,
        flag: csie_pkg::RESET_FLAG,
        sync1: '0,
        sync2: '0,
        sync3: '0,
        level: '0,
        rdata: csie_pkg::READ_IDLE,
        irq: 1'b0
    };

    csie_state_t state; // Current state
    csie_state_t next_state; // Next state
    logic rst_meta_n; // Reset synchroniser first stage
    logic rst_sync_n; // Released reset used by the rest of the block

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    // Assert at once, release two edges later so no flop sees a ragged edge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    logic [31:0] wdata_impl; // Write data limited to implemented bits
    logic wr_clear; // Accepted write to the clear view
    logic wr_set; // Accepted write to the set view
    logic wr_flag; // Write to the flag register
    logic [31:0] status_word; // Accepted status levels as a word
    logic [31:0] status_rise; // Zero-to-one changes this cycle

    // Reserved bits are stripped here, so they can never be stored
    // Software should write zeros there anyway, but nothing here relies on it
    assign wdata_impl = reg_wdata[31:0] & csie_pkg::IMPL_MASK;
    // Protection blocks only the enable views, flags stay clearable
    assign wr_clear = reg_wr && !write_protect
        && (reg_addr == csie_pkg::OFF_ENABLE_CLEAR[ADDR_W-1:0]);
    assign wr_set = reg_wr && !write_protect
        && (reg_addr == csie_pkg::OFF_ENABLE_SET[ADDR_W-1:0]);
    assign wr_flag = reg_wr && (reg_addr == csie_pkg::OFF_FLAG[ADDR_W-1:0]);
    // Read-only copy of the filtered levels, handy when a flag looks stale
    assign status_word = {{(32 - csie_pkg::NUM_SRC){1'b0}}, state.level}
        & csie_pkg::IMPL_MASK;

    // A change counts once the second and third stages agree
    always_comb begin
        status_rise = 32'h0000_0000;
        for (int i = 0; i < csie_pkg::NUM_SRC; i++) begin
            status_rise[i] = state.sync2[i] && state.sync3[i] && !state.level[i];
        end
        status_rise = status_rise & csie_pkg::IMPL_MASK;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        logic [31:0] set_bits;
        logic [31:0] clr_bits;
        logic [31:0] ack_bits;
        set_bits = 32'h0000_0000;
        clr_bits = 32'h0000_0000;
        ack_bits = 32'h0000_0000;
        next_state = state;

        // Three-stage synchroniser, the filtered level follows agreement
        next_state.sync1 = src_status;
        next_state.sync2 = state.sync1;
        next_state.sync3 = state.sync2;
        for (int i = 0; i < csie_pkg::NUM_SRC; i++) begin
            if (state.sync2[i] == state.sync3[i]) begin
                next_state.level[i] = state.sync3[i];
            end
        end

        // Ones on the views act, zeros do nothing; no read-modify-write needed
        if (wr_set) begin
            set_bits = wdata_impl;
        end
        if (wr_clear) begin
            clr_bits = wdata_impl;
        end
        // One mask behind both views; clear wins should both ever hit a bit
        next_state.enable = ((state.enable | set_bits) & ~clr_bits)
            & csie_pkg::IMPL_MASK;

        // Write-one clears a flag, but a rise in the same cycle is kept
        if (wr_flag) begin
            ack_bits = wdata_impl;
        end
        next_state.flag = ((state.flag & ~ack_bits) | status_rise)
            & csie_pkg::IMPL_MASK;

        // Request from the next values, so it matches the registers it mirrors
        next_state.irq = |(next_state.flag & next_state.enable);

        // Read data for the cycle after the strobe only; unmapped reads zero
        next_state.rdata = csie_pkg::READ_IDLE;
        if (reg_rd) begin
            case (reg_addr)
                csie_pkg::OFF_ENABLE_CLEAR[ADDR_W-1:0]: begin
                    next_state.rdata = state.enable;
                end
                csie_pkg::OFF_ENABLE_SET[ADDR_W-1:0]: begin
                    next_state.rdata = state.enable;
                end
                csie_pkg::OFF_FLAG[ADDR_W-1:0]: begin
                    next_state.rdata = state.flag;
                end
                csie_pkg::OFF_STATUS[ADDR_W-1:0]: begin
                    next_state.rdata = status_word;
                end
                default: begin
                    next_state.rdata = csie_pkg::READ_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    // Enables return to zero on reset, leaving every source disabled
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops

    assign reg_rdata = state.rdata[DATA_W-1:0];
    assign irq_req = state.irq;
    assign irq_enable_mask = state.enable[DATA_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Source groups, for the position checks below

    // Built from the single positions, apart from the implemented mask, so a
    // slip in either one shows up as a failing check rather than a quiet match

    // Digital PLL lock events
    localparam logic [31:0] PLL_IE_BITS =
        (32'h0000_0001 << csie_pkg::BIT_PLL_LOCK_TIMEOUT)
        | (32'h0000_0001 << csie_pkg::BIT_PLL_LOCK_FALL)
        | (32'h0000_0001 << csie_pkg::BIT_PLL_LOCK_RISE);

    // Brown-out detector events
    localparam logic [31:0] BROWNOUT_IE_BITS =
        (32'h0000_0001 << csie_pkg::BIT_BROWNOUT_SYNC_READY)
        | (32'h0000_0001 << csie_pkg::BIT_BROWNOUT_DETECT)
        | (32'h0000_0001 << csie_pkg::BIT_BROWNOUT_READY);

    // Frequency-locked loop reference and lock events
    localparam logic [31:0] FLL_LOCK_IE_BITS =
        (32'h0000_0001 << csie_pkg::BIT_FLL_REF_STOPPED)
        | (32'h0000_0001 << csie_pkg::BIT_FLL_LOCK_COARSE)
        | (32'h0000_0001 << csie_pkg::BIT_FLL_LOCK_FINE);

    // Frequency-locked loop bounds and ready events
    localparam logic [31:0] FLL_MISC_IE_BITS =
        (32'h0000_0001 << csie_pkg::BIT_FLL_OUT_OF_BOUNDS)
        | (32'h0000_0001 << csie_pkg::BIT_FLL_READY);

    // Internal oscillator ready events
    localparam logic [31:0] RC_OSC_IE_BITS =
        (32'h0000_0001 << csie_pkg::BIT_RC8M_READY)
        | (32'h0000_0001 << csie_pkg::BIT_RC32K_READY);

    // Crystal oscillator ready events
    localparam logic [31:0] XTAL_IE_BITS =
        (32'h0000_0001 << csie_pkg::BIT_XTAL32K_READY)
        | (32'h0000_0001 << csie_pkg::BIT_XTAL_READY);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    a_clear_view_clears: assert property (
        wr_clear |=> ((state.enable & $past(wdata_impl)) == 32'h0000_0000))
        else $error("clear view left an enable set");

    a_zero_write_keeps: assert property (
        (wr_set || wr_clear) |=>
            (((state.enable ^ $past(state.enable)) & ~$past(wdata_impl)) == 32'h0000_0000))
        else $error("zero write changed an enable");

    a_set_view_sets: assert property (
        wr_set |=> ((state.enable & $past(wdata_impl)) == $past(wdata_impl)))
        else $error("set view did not set enables");

    a_views_read_same: assert property (
        (reg_rd && (reg_addr == csie_pkg::OFF_ENABLE_CLEAR[ADDR_W-1:0]
            || reg_addr == csie_pkg::OFF_ENABLE_SET[ADDR_W-1:0]))
        |=> (reg_rdata == $past(state.enable)))
        else $error("enable view read did not show the mask");

    a_request_matches: assert property (
        irq_req == |(state.flag & state.enable))
        else $error("request does not match flags and enables");

    a_reserved_zero: assert property (
        ((reg_rdata & ~csie_pkg::IMPL_MASK) == 32'h0000_0000)
        && ((state.enable & ~csie_pkg::IMPL_MASK) == 32'h0000_0000))
        else $error("reserved bits not zero");

    a_protect_holds: assert property (
        (write_protect && !wr_set && !wr_clear) |=> $stable(state.enable))
        else $error("enable changed under protection");

    a_flag_on_rise: assert property (
        (status_rise != 32'h0000_0000) |=> ((state.flag & $past(status_rise)) == $past(status_rise)))
        else $error("status rise did not set its flag");

    a_flag_write_clears: assert property (
        wr_flag && ((wdata_impl & status_rise) == 32'h0000_0000)
        |=> ((state.flag & $past(wdata_impl)) == 32'h0000_0000))
        else $error("write one did not clear the flag");

    a_no_enable_drift: assert property (
        (!wr_set && !wr_clear) |=> $stable(state.enable))
        else $error("enable changed without a write");

    // A one written through the set view must land on its own position
    a_pll_bits_land: assert property (
        wr_set |=> ((state.enable & $past(reg_wdata[31:0]) & PLL_IE_BITS)
            == ($past(reg_wdata[31:0]) & PLL_IE_BITS)))
        else $error("pll enable bits missed their positions");

    a_brownout_bits_land: assert property (
        wr_set |=> ((state.enable & $past(reg_wdata[31:0]) & BROWNOUT_IE_BITS)
            == ($past(reg_wdata[31:0]) & BROWNOUT_IE_BITS)))
        else $error("brown-out enable bits missed their positions");

    a_fll_lock_bits_land: assert property (
        wr_set |=> ((state.enable & $past(reg_wdata[31:0]) & FLL_LOCK_IE_BITS)
            == ($past(reg_wdata[31:0]) & FLL_LOCK_IE_BITS)))
        else $error("fll lock enable bits missed their positions");

    a_fll_misc_bits_land: assert property (
        wr_set |=> ((state.enable & $past(reg_wdata[31:0]) & FLL_MISC_IE_BITS)
            == ($past(reg_wdata[31:0]) & FLL_MISC_IE_BITS)))
        else $error("fll bounds or ready enable bits missed their positions");

    a_rc_osc_bits_land: assert property (
        wr_set |=> ((state.enable & $past(reg_wdata[31:0]) & RC_OSC_IE_BITS)
            == ($past(reg_wdata[31:0]) & RC_OSC_IE_BITS)))
        else $error("internal oscillator enable bits missed their positions");

    a_xtal_bits_land: assert property (
        wr_set |=> ((state.enable & $past(reg_wdata[31:0]) & XTAL_IE_BITS)
            == ($past(reg_wdata[31:0]) & XTAL_IE_BITS)))
        else $error("crystal enable bits missed their positions");

    // First edge out of reset: every source still disabled, no request
    a_reset_disabled: assert property (
        $rose(rst_sync_n) |-> ((state.enable == csie_pkg::RESET_ENABLE) && !irq_req))
        else $error("enables not cleared by reset");

    // Read data lives one cycle; a stale word could be taken as a fresh read
    a_read_idle_zero: assert property (
        !reg_rd |=> (reg_rdata == csie_pkg::READ_IDLE[DATA_W-1:0]))
        else $error("read data stood past its cycle");

    // The filtered level moves only where the second and third stages agreed
    a_level_needs_agree: assert property (
        (((state.level ^ $past(state.level)) & $past(state.sync2 ^ state.sync3)) == '0))
        else $error("status level moved before the stages agreed");

    c_enable_then_irq: cover property (
        wr_set ##[1:20] irq_req);
    c_clear_while_irq: cover property (
        irq_req ##0 wr_clear ##1 !irq_req);
    c_protected_write: cover property (
        reg_wr && write_protect);
    c_flag_ack_and_rise: cover property (
        wr_flag && ((wdata_impl & status_rise) != 32'h0000_0000));
    c_read_after_set: cover property (
        wr_set ##2 (reg_rd && (reg_addr == csie_pkg::OFF_ENABLE_CLEAR[ADDR_W-1:0])));

endmodule : csie_top

// File: testbench/csie_top_test.sv
// Self-checking bench for the clock-source interrupt-enable block
`timescale 1ns/10ps

module csie_top_test;

    ////////////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic core_clk = 1'b0; // 100 ns period
    logic rstn; // Driven low at time zero so the reset edge is seen
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic write_protect = 1'b0;
    logic [csie_pkg::NUM_SRC-1:0] src_status = '0;
    logic irq_req;
    logic [31:0] irq_enable_mask;
    int n_mismatch = 0; // Mismatches seen
    int check_count = 0; // Comparisons made
    logic [31:0] bit_w; // One-hot write word

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and design
    always #50 core_clk = ~core_clk;

    csie_top DUT (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .write_protect(write_protect), .src_status(src_status),
        .irq_req(irq_req), .irq_enable_mask(irq_enable_mask));

    ////////////////////////////////////////////////////////////////////////////////
    // Access tasks: strobes launched and dropped right after rising edges
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : reg_write

    // Read data stands only in the cycle after the strobe, so sample there
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : check_word

    task automatic check_bit(input string what, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %b seen %b", what, e, g);
        end
    endtask : check_bit

    // Both views and the mask port must agree with one expected mask
    task automatic check_views(input logic [31:0] e);
        logic [31:0] v;
        reg_read(csie_pkg::OFF_ENABLE_CLEAR, v);
        check_word("clear view", e, v);
        reg_read(csie_pkg::OFF_ENABLE_SET, v);
        check_word("set view", e, v);
        check_word("mask port", e, irq_enable_mask);
    endtask : check_views

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the tests need well under 2000 cycles
    initial begin
        #500000;
        n_mismatch++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] v;
        rstn <= 1'b0;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check_bit("irq after reset", 1'b0, irq_req);
        check_views(csie_pkg::RESET_ENABLE);
        // Every bit position, reserved ones included, through both views
        for (int i = 0; i < 32; i++) begin
            bit_w = 32'h0000_0001 << i;
            // Bulk writes keep reserved bits zero; the one-hot word pokes them on purpose
            reg_write(csie_pkg::OFF_ENABLE_CLEAR, csie_pkg::IMPL_MASK);
            reg_write(csie_pkg::OFF_ENABLE_SET, bit_w);
            check_views(csie_pkg::IMPL_MASK & bit_w);
            reg_write(csie_pkg::OFF_ENABLE_SET, csie_pkg::IMPL_MASK);
            reg_write(csie_pkg::OFF_ENABLE_CLEAR, bit_w);
            check_views(csie_pkg::IMPL_MASK & ~bit_w);
        end
        // Zero writes through either view change nothing
        reg_write(csie_pkg::OFF_ENABLE_SET, 32'h0000_0000);
        reg_write(csie_pkg::OFF_ENABLE_CLEAR, 32'h0000_0000);
        check_views(csie_pkg::IMPL_MASK & ~32'h8000_0000);
        // Protected writes are dropped on both views
        reg_write(csie_pkg::OFF_ENABLE_CLEAR, csie_pkg::IMPL_MASK);
        reg_write(csie_pkg::OFF_ENABLE_SET, 32'h0000_00f0);
        write_protect <= 1'b1;
        reg_write(csie_pkg::OFF_ENABLE_SET, 32'h0003_8f0f);
        reg_write(csie_pkg::OFF_ENABLE_CLEAR, 32'h0000_00f0);
        write_protect <= 1'b0;
        check_views(32'h0000_00f0);
        // Enabled source: a status rise sets its flag and raises the request
        reg_write(csie_pkg::OFF_ENABLE_CLEAR, 32'h0000_00ef);
        src_status[csie_pkg::BIT_FLL_READY] <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        check_bit("irq enabled flag", 1'b1, irq_req);
        reg_read(csie_pkg::OFF_FLAG, v);
        check_word("flags", 32'h0000_0010, v);
        // A level that stays high does not set the flag again once cleared
        reg_write(csie_pkg::OFF_FLAG, 32'h0000_0010);
        repeat (6) @(posedge core_clk);
        #1;
        check_bit("irq after flag clear", 1'b0, irq_req);
        reg_read(csie_pkg::OFF_FLAG, v);
        check_word("flags after clear", 32'h0000_0000, v);
        // Disabled source: flag set but no request until enabled
        src_status[csie_pkg::BIT_XTAL_READY] <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1;
        check_bit("irq disabled flag", 1'b0, irq_req);
        reg_read(csie_pkg::OFF_FLAG, v);
        check_word("flags disabled source",
            32'h0000_0001 << csie_pkg::BIT_XTAL_READY, v);
        reg_read(csie_pkg::OFF_STATUS, v);
        check_word("status levels", (32'h0000_0001 << csie_pkg::BIT_XTAL_READY)
            | (32'h0000_0001 << csie_pkg::BIT_FLL_READY), v);
        // Read data must be gone again one cycle later
        @(posedge core_clk);
        #1;
        check_word("read data after its cycle", csie_pkg::READ_IDLE, reg_rdata);
        reg_write(csie_pkg::OFF_ENABLE_SET, 32'h0000_0001);
        check_bit("irq on enable", 1'b1, irq_req);
        reg_write(csie_pkg::OFF_ENABLE_CLEAR, 32'h0000_0001);
        check_bit("irq on disable", 1'b0, irq_req);
        reg_read(8'h10, v);
        check_word("unmapped read", csie_pkg::READ_IDLE, v);
        // Reset in mid-run returns the mask to all-disabled
        @(posedge core_clk);
        rstn <= 1'b0;
        @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        check_views(csie_pkg::RESET_ENABLE);
        check_bit("irq after mid reset", 1'b0, irq_req);
        print_verdict();
    end

endmodule : csie_top_test
